// [inc/mcsd_pkg.sv]
// constants shared by both ends of the memory chip-select decoder
// assumes a 16-bit data, 20-bit address external bus and 8 ram chips
// What this block does
// - bus is 16 data bits, 20 address bits
// - ram lower lane enabled when A0 low
// - ram upper lane follows high-byte strobe
// - both lanes low transfers whole word
// - master puts cpu full words on even addresses; camera words go to camAddr unrounded
// - camera word enable forces both lanes on
// - 10-bit pixel stored as 16-bit word
// - ram gets A1-A18, roms get A1-A17
// - A19 picks ram chip within window
// - flash selected: region select low, A18 high
// - prom selected: region select low, A18 low
// - two byte roms act as one word device
// - ram select ANDs controller and camera selects
// - five selects plus A18/A19 give 10 outputs
// - region select low when no other select
// - window config: 12-bit start, 4-bit length
// - shared output enable for all reads
// - shared write strobe; prom write via jumper
package mcsd_pkg;
    localparam int DATA_W      = 16;
    localparam int ADDR_W      = 20;
    localparam int FULL_ADDR_W = 24;
    localparam int CS_N        = 5;
    localparam int RAM_N       = 8;
    localparam int PIXEL_W     = 10;
    localparam int RAM_ADDR_W  = 18;
    localparam int ROM_ADDR_W  = 17;
    localparam int ROM_BANK_BIT = 18;
    localparam int RAM_CHIP_BIT = 19;
    localparam int WIN_START_W = 12;
    localparam int WIN_LEN_W   = 4;
    localparam int WIN_PAGE_LSB = 12;
    localparam int WIN_N       = 4;
    // window config word: start in [15:4], length in [3:0]
    localparam int WIN_START_LSB = 4;
    localparam int WIN_LEN_LSB   = 0;
    localparam logic [15:0] WIN_RST [WIN_N] =
        '{16'h0808, 16'h1808, 16'h2808, 16'h3808};
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef enum logic [1:0]
    {
        MCSD_IDLE   = 2'b00,
        MCSD_ACCESS = 2'b01,
        MCSD_CAMWR  = 2'b10
    } mcsd_state_t;
endpackage

// [inc/mcsd_bus_if.sv]
// signals between the bus-master end and the chip-select decoder
// assumes both ends are joined by the testbench
`timescale 1ns/1ns
interface mcsd_bus_if;
    logic [mcsd_pkg::CS_N-1:0]   csN;
    logic [mcsd_pkg::ADDR_W-1:0] addr;
    logic                        highByteStrobeN;
    logic                        rdN;
    logic                        wrN;
    logic                        camWordEn;
    logic [mcsd_pkg::RAM_N-1:0]  camSegSelN;
    logic [mcsd_pkg::DATA_W-1:0] dataOut;
    logic                        dataOe;

    modport master
    (
        output csN, addr, highByteStrobeN, rdN, wrN,
        output camWordEn, camSegSelN, dataOut, dataOe
    );
    modport decoder
    (
        input csN, addr, highByteStrobeN, rdN, wrN,
        input camWordEn, camSegSelN, dataOut, dataOe
    );
endinterface

// [logic/mcsd_decoder.sv]
// chip-select and byte-lane decoder between bus and memory chips
// assumes the master end keeps csN[0] low when no other select is low
`timescale 1ns/1ns
module mcsd_decoder
(
    mcsd_bus_if.decoder                     bus,
    input  wire logic                       promProgJumper,
    output wire logic                       promSelN,
    output wire logic                       flashSelN,
    output wire logic [mcsd_pkg::RAM_N-1:0] ramSelN,
    output wire logic                       upperLaneSelN,
    output wire logic                       lowerLaneSelN,
    output wire logic [mcsd_pkg::RAM_ADDR_W-1:0] ramAddr,
    output wire logic [mcsd_pkg::ROM_ADDR_W-1:0] romAddr,
    output wire logic                       memOeN,
    output wire logic                       memWeN,
    output wire logic                       promWeN,
    output wire logic [mcsd_pkg::DATA_W-1:0] memDataOut,
    output wire logic                       memDataOe
);
    // no clock here: glue logic only, outputs follow inputs
    ////////////////////////////////////////////////////////////////////
    wire romRegionSelN = bus.csN[0];
    wire romBank       = bus.addr[mcsd_pkg::ROM_BANK_BIT];
    wire ramChip       = bus.addr[mcsd_pkg::RAM_CHIP_BIT];

    assign flashSelN = romRegionSelN | ~romBank;
    assign promSelN  = romRegionSelN | romBank;

    // A0 is the lane select, so chips see the word address
    assign ramAddr = bus.addr[mcsd_pkg::RAM_ADDR_W:1];
    assign romAddr = bus.addr[mcsd_pkg::ROM_ADDR_W:1];

    ////////////////////////////////////////////////////////////////////
    // two ram chips per controller window
    genvar i;
    generate
        for (i = 0; i < mcsd_pkg::RAM_N; i++)
        begin : g_ram
            wire ctrlSelN = bus.csN[1 + i/2] |
                            (ramChip != 1'(i % 2));
            assign ramSelN[i] = ctrlSelN & bus.camSegSelN[i];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // lanes are shared by ram and both byte-wide roms
    assign lowerLaneSelN = ~bus.camWordEn & bus.addr[0];
    assign upperLaneSelN = ~bus.camWordEn & bus.highByteStrobeN;
    // both low gives the whole word on the 16-bit path

    ////////////////////////////////////////////////////////////////////
    assign memOeN  = bus.rdN;
    assign memWeN  = bus.wrN;
    // prom write pin stays high unless the jumper is fitted
    assign promWeN = promProgJumper ? bus.wrN : 1'b1;
    assign memDataOut = bus.dataOut;
    assign memDataOe  = bus.dataOe;
endmodule

// [logic/mcsd_bus_master.sv]
// bus master end: controller windows, access strobes and camera writes
// assumes one request at a time; ready shows when the next is taken
`timescale 1ns/1ns
module mcsd_bus_master
(
    input  wire logic                            clock,
    input  wire logic                            sys_rst,
    mcsd_bus_if.master                           bus,
    input  wire logic [15:0]                     windowConfig [mcsd_pkg::WIN_N],
    input  wire logic                            reqValid,
    input  wire logic                            reqWrite,
    input  wire logic                            reqByte,
    input  wire logic [mcsd_pkg::FULL_ADDR_W-1:0] reqAddr,
    input  wire logic [mcsd_pkg::DATA_W-1:0]     reqData,
    input  wire logic                            camCapture,
    input  wire logic                            camPixelValid,
    input  wire logic [mcsd_pkg::PIXEL_W-1:0]    camPixel,
    input  wire logic [2:0]                      camRamIdx,
    input  wire logic [mcsd_pkg::ADDR_W-1:0]     camAddr,
    output logic                                 reqReady,
    output logic                                 misaligned
);
    ////////////////////////////////////////////////////////////////////
    mcsd_pkg::mcsd_state_t state_ff;
    mcsd_pkg::mcsd_state_t nxt_state;
    logic [mcsd_pkg::CS_N-1:0] csN_ff;
    logic [mcsd_pkg::ADDR_W-1:0] addr_ff;
    logic hbeN_ff, rdN_ff, wrN_ff, wordEn_ff, dataOe_ff;
    logic [mcsd_pkg::RAM_N-1:0] segN_ff;
    logic [mcsd_pkg::DATA_W-1:0] data_ff;
    logic ready_ff, misaligned_ff;

    // window hit: page within [start, start + 2^len)
    logic [mcsd_pkg::WIN_N-1:0] winHit;
    wire [11:0] reqPage = reqAddr[mcsd_pkg::FULL_ADDR_W-1:
                                  mcsd_pkg::WIN_PAGE_LSB];
    genvar w;
    generate
        for (w = 0; w < mcsd_pkg::WIN_N; w++)
        begin : g_win
            wire [11:0] start = windowConfig[w][15:mcsd_pkg::WIN_START_LSB];
            wire [3:0]  len   = windowConfig[w][3:mcsd_pkg::WIN_LEN_LSB];
            wire [12:0] lim   = {1'b0, start} + (13'h0001 << len);
            assign winHit[w] = (reqPage >= start) &&
                               ({1'b0, reqPage} < lim);
        end
    endgenerate
    // first window wins; region select catches everything else
    wire [mcsd_pkg::CS_N-1:0] nxtCsN =
        winHit[0] ? 5'h1d : winHit[1] ? 5'h1b :
        winHit[2] ? 5'h17 : winHit[3] ? 5'h0f : 5'h1e;
    wire wordAcc = ~reqByte;
    // odd full-word requests are rounded down to the even address
    wire [mcsd_pkg::ADDR_W-1:0] reqBusAddr =
        {reqAddr[mcsd_pkg::ADDR_W-1:1], reqAddr[0] & reqByte};
    wire reqHbeN = reqByte & ~reqAddr[0];
    wire [mcsd_pkg::RAM_N-1:0] camSegN = ~(8'h01 << camRamIdx);
    // ready gates the request take so the first edge after reset takes no cpu request; a camera write is not gated
    wire takeReq = (state_ff == mcsd_pkg::MCSD_IDLE) && ready_ff &&
                   reqValid && ~camCapture;
    wire takeCam = (state_ff == mcsd_pkg::MCSD_IDLE) && camCapture &&
                   camPixelValid;

    always_comb
    begin
        nxt_state = mcsd_pkg::MCSD_IDLE;
        case (state_ff)
            mcsd_pkg::MCSD_IDLE:
                nxt_state = takeCam ? mcsd_pkg::MCSD_CAMWR :
                            takeReq ? mcsd_pkg::MCSD_ACCESS :
                            mcsd_pkg::MCSD_IDLE;
            default:
                nxt_state = mcsd_pkg::MCSD_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_ff      <= mcsd_pkg::MCSD_IDLE;
            csN_ff        <= 5'h1e;
            addr_ff       <= 20'h00000;
            hbeN_ff       <= 1'b1;
            rdN_ff        <= 1'b1;
            wrN_ff        <= 1'b1;
            wordEn_ff     <= 1'b0;
            segN_ff       <= 8'hff;
            data_ff       <= mcsd_pkg::DATA_RST;
            dataOe_ff     <= 1'b0;
            ready_ff      <= 1'b0;
            misaligned_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            ready_ff <= (nxt_state == mcsd_pkg::MCSD_IDLE);
            rdN_ff   <= ~(takeReq & ~reqWrite);
            wrN_ff   <= ~(takeCam | (takeReq & reqWrite));
            dataOe_ff <= takeCam | (takeReq & reqWrite);
            wordEn_ff <= takeCam;
            segN_ff   <= takeCam ? camSegN : 8'hff;
            if (takeCam)
            begin
                addr_ff <= camAddr;
                csN_ff  <= 5'h1e;
                hbeN_ff <= 1'b1;
                data_ff <= {6'h00, camPixel};
            end
            else if (takeReq)
            begin
                addr_ff <= reqBusAddr;
                csN_ff  <= nxtCsN;
                hbeN_ff <= reqHbeN & ~wordAcc;
                data_ff <= reqData;
                misaligned_ff <= wordAcc & reqAddr[0];
            end
            else
            begin
                csN_ff  <= 5'h1e;
                hbeN_ff <= 1'b1;
            end
        end
    end

    assign bus.csN             = csN_ff;
    assign bus.addr            = addr_ff;
    assign bus.highByteStrobeN = hbeN_ff;
    assign bus.rdN             = rdN_ff;
    assign bus.wrN             = wrN_ff;
    assign bus.camWordEn       = wordEn_ff;
    assign bus.camSegSelN      = segN_ff;
    assign bus.dataOut         = data_ff;
    assign bus.dataOe          = dataOe_ff;
    assign reqReady            = ready_ff;
    assign misaligned          = misaligned_ff;
endmodule

// [sim/mcsd_bus_chk.sv]
// bus checks between master end and decoder end
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ns
module mcsd_bus_chk
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic [4:0]  csN,
    input wire logic        rdN,
    input wire logic        wrN,
    input wire logic        camWordEn,
    input wire logic [7:0]  camSegSelN,
    input wire logic [15:0] dataOut,
    input wire logic        dataOe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////
    property p_rdPulse; !rdN |=> rdN; endproperty
    a_rdPulse: assert property (p_rdPulse)
        else $error("read strobe held too long");
    property p_wrPulse; !wrN |=> wrN; endproperty
    a_wrPulse: assert property (p_wrPulse)
        else $error("write strobe held too long");
    property p_camSel; camWordEn |-> $onehot(~camSegSelN); endproperty
    a_camSel: assert property (p_camSel)
        else $error("camera select not one-hot");
    property p_camWr; camWordEn |-> !wrN && dataOe && csN == 5'h1e;
    endproperty
    a_camWr: assert property (p_camWr)
        else $error("camera word without write");
    property p_noCam; !camWordEn |-> camSegSelN == 8'hff; endproperty
    a_noCam: assert property (p_noCam)
        else $error("camera select outside camera write");
    property p_excl; !(rdN == 1'b0 && wrN == 1'b0); endproperty
    a_excl: assert property (p_excl)
        else $error("read and write strobes together");
    property p_csRel; csN != 5'h1e |=> csN == 5'h1e; endproperty
    a_csRel: assert property (p_csRel)
        else $error("chip select not released");
    property p_pix; camWordEn |-> dataOut[15:10] == 6'h0; endproperty
    a_pix: assert property (p_pix)
        else $error("pixel not zero-extended");
    c_cam: cover property (camWordEn);
    c_rd: cover property (!rdN);
    c_wr: cover property (!wrN && !camWordEn);
endmodule

// [sim/memory_chip_select_decoder_tb.sv]
// bench for master and decoder joined by the bus interface
// assumes default windows from the package
`timescale 1ns/1ns
module memory_chip_select_decoder_tb;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] winCfg [mcsd_pkg::WIN_N] = mcsd_pkg::WIN_RST;
    logic        jmp = 1'b0;
    logic        reqValid = 1'b0;
    logic        reqWrite = 1'b0;
    logic        reqByte = 1'b0;
    logic [23:0] reqAddr = 24'h0;
    logic [15:0] reqData = 16'h0;
    logic        camCap = 1'b0;
    logic        camPv = 1'b0;
    logic [9:0]  camPixel = 10'h0;
    logic [2:0]  camIdx = 3'h0;
    logic [19:0] camAddr = 20'h0;
    logic        reqReady, misaligned, promSelN, flashSelN, upN, loN;
    logic        memOeN, memWeN, promWeN, memDataOe;
    logic [7:0]  ramSelN;
    logic [17:0] ramAddr;
    logic [16:0] romAddr;
    logic [15:0] memDataOut;
    int          seed = 32'h4f99;
    int          n_mismatch = 0;
    int          total_checks = 0;
    logic [15:0] pixQ [$];
    always #20 clock = ~clock;
    mcsd_bus_if mcsd_bus_if_i ();
    mcsd_bus_master mcsd_bus_master_i
    (.clock(clock), .sys_rst(sys_rst), .bus(mcsd_bus_if_i),
     .windowConfig(winCfg), .reqValid(reqValid), .reqWrite(reqWrite),
     .reqByte(reqByte), .reqAddr(reqAddr), .reqData(reqData),
     .camCapture(camCap), .camPixelValid(camPv), .camPixel(camPixel),
     .camRamIdx(camIdx), .camAddr(camAddr), .reqReady(reqReady),
     .misaligned(misaligned));
    mcsd_decoder mcsd_decoder_i
    (.bus(mcsd_bus_if_i), .promProgJumper(jmp), .promSelN(promSelN),
     .flashSelN(flashSelN), .ramSelN(ramSelN), .upperLaneSelN(upN),
     .lowerLaneSelN(loN), .ramAddr(ramAddr), .romAddr(romAddr),
     .memOeN(memOeN), .memWeN(memWeN), .promWeN(promWeN),
     .memDataOut(memDataOut), .memDataOe(memDataOe));
    mcsd_bus_chk mcsd_bus_chk_i
    (.clock(clock), .sys_rst(sys_rst), .csN(mcsd_bus_if_i.csN),
     .rdN(mcsd_bus_if_i.rdN), .wrN(mcsd_bus_if_i.wrN),
     .camWordEn(mcsd_bus_if_i.camWordEn),
     .camSegSelN(mcsd_bus_if_i.camSegSelN),
     .dataOut(mcsd_bus_if_i.dataOut), .dataOe(mcsd_bus_if_i.dataOe));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // bounded wait at falling edges; a hang counts as a mismatch
    task automatic waitFor(input logic cam);
        int i;
        for (i = 0; i < 20; i++)
        begin
            if ((cam ? mcsd_bus_if_i.camWordEn : reqReady) === 1'b1)
                break;
            @(negedge clock);
        end
        if (i == 20)
        begin
            n_mismatch++;
            results();
        end
    endtask
    // valid stands until the edge that sees ready high, then drops
    task automatic doReq(input logic wr, input logic by,
                         input logic [23:0] a);
        logic [19:0] ea;
        logic [7:0]  er;
        int          k;
        ea = by ? a[19:0] : {a[19:1], 1'b0};
        k = (a < 24'h080000 || a >= 24'h480000) ? 0 :
            int'((a - 24'h080000) >> 20) + 1;
        er = (k != 0) ? ~(8'h01 << (2 * (k - 1) + ea[19])) : 8'hff;
        {reqWrite, reqByte, reqAddr} = {wr, by, a};
        reqData = 16'($random(seed));
        jmp = 1'($random(seed));
        reqValid = 1'b1;
        waitFor(1'b0);
        @(negedge clock);
        reqValid = 1'b0;
        chk("prom", !(k == 0 && !ea[18]), promSelN);
        chk("flash", !(k == 0 && ea[18]), flashSelN);
        chk("ram", er, ramSelN);
        chk("lower", by && ea[0], loN);
        chk("upper", by && !ea[0], upN);
        chk("oe", wr, memOeN);
        chk("we", !wr, memWeN);
        chk("promWe", !(wr && jmp), promWeN);
        chk("dataOe", wr, memDataOe);
        chk("ramAddr", ea[18:1], ramAddr);
        chk("romAddr", ea[17:1], romAddr);
        chk("misaligned", !by && a[0], misaligned);
        if (wr)
            chk("data", reqData, memDataOut);
        @(negedge clock);
    endtask
    task automatic doCam(input int idx);
        logic [7:0] er;
        er = ~(8'h01 << idx);
        camIdx = idx[2:0];
        camPixel = 10'($random(seed));
        camAddr = 20'($random(seed));
        pixQ.push_back({6'h00, camPixel});
        {camCap, camPv} = 2'b11;
        waitFor(1'b1);
        {camCap, camPv} = 2'b00;
        chk("camRam", er, ramSelN);
        chk("camLanes", 2'b00, {upN, loN});
        chk("camWe", 1'b0, memWeN);
        chk("camDataOe", 1'b1, memDataOe);
        chk("camData", pixQ.pop_front(), memDataOut);
        chk("camAddr", camAddr[18:1], ramAddr);
        @(negedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(negedge clock);
        chk("rstRam", 8'hff, ramSelN);
        chk("rstReady", 1'b0, reqReady);
        sys_rst = 1'b0;
        $display("reset test done");
        doReq(1'b0, 1'b0, 24'h0c0003);
        // range reaches past the last window to hit the catch-all
        for (int n = 0; n < 48; n++)
            doReq(1'($random(seed)), 1'($random(seed)),
                  24'($unsigned($random(seed)) % 32'h600000));
        $display("cpu access test done");
        for (int n = 0; n < 8; n++)
            doCam(n);
        $display("camera test done");
        results();
    end
endmodule
